/* design/ctc_pkg.sv */
// Constants and carrier types for the core timer control block.
// Assumes one 40 MHz module clock and a 16-bit plain register port.
package ctc_pkg;
    // ======================================================
    // Register map
    localparam logic [15:0] ADDR_CONTROL = 16'hFF42;
    localparam logic [15:0] ADDR_COUNT = 16'hFE42;
    localparam logic [12:0] CONTROL_RESET = 13'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_MIN = 16'h0000;
    localparam logic [15:0] COUNT_STEP = 16'h0001;

    // ======================================================
    // Field positions of the control register
    localparam int POS_IPAR = 0;
    localparam int POS_MODE = 3;
    localparam int POS_RUN = 6;
    localparam int POS_SWDIR = 7;
    localparam int POS_EXTDIR = 8;
    localparam int POS_OE = 9;
    localparam int POS_OTL = 10;
    localparam int POS_BPS = 11;
    localparam int POS_EDGE = 13;
    localparam int POS_CHDIR = 14;
    localparam int POS_RDIR = 15;

    // ======================================================
    // Operating modes and input parameter codes
    typedef enum logic [2:0] {
        MODE_TIMER = 3'h0,
        MODE_COUNTER = 3'h1,
        MODE_GATED_LO = 3'h2,
        MODE_GATED_HI = 3'h3,
        MODE_RSVD_A = 3'h4,
        MODE_RSVD_B = 3'h5,
        MODE_INCR_ROT = 3'h6,
        MODE_INCR_EDGE = 3'h7
    } ctc_mode_type;
    localparam logic [2:0] EDGE_RISE = 3'h1;
    localparam logic [2:0] EDGE_FALL = 3'h2;
    localparam logic [2:0] EDGE_BOTH = 3'h3;
    localparam logic [1:0] INCR_A = 2'h1;
    localparam logic [1:0] INCR_B = 2'h2;
    localparam logic [1:0] INCR_AB = 2'h3;

    // ======================================================
    // Block prescaler as power-of-two shift: /8, /4, /32, /16
    localparam logic [3:0] BPS_SHIFT_0 = 4'h3;
    localparam logic [3:0] BPS_SHIFT_1 = 4'h2;
    localparam logic [3:0] BPS_SHIFT_2 = 4'h5;
    localparam logic [3:0] BPS_SHIFT_3 = 4'h4;
    localparam logic [11:0] DIV_ONES = 12'hFFF;
    localparam logic [11:0] DIV_STEP = 12'h001;

    // ======================================================
    // Carriers
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ctc_bus_type;

    typedef struct packed {
        logic ext_dir_input;
        logic gate_count_input;
    } ctc_pins_type;

    typedef struct packed {
        logic toggle_latch;
        logic shadow_latch;
    } ctc_trig_type;

    typedef struct packed {
        logic [1:0] prev;
        logic primed;
    } ctc_edge_state_type;

    typedef struct packed {
        logic [15:0] cnt;
        logic [11:0] div;
        logic [12:0] ctl;
        logic edge_flag;
        logic chdir;
        logic rdir;
        logic quad_down;
        logic shadow;
        logic ovf;
        logic [15:0] rdata;
    } ctc_state_type;
endpackage

/* design/ctc_edge_detect.sv */
// Edge detector for the two timer input pins.
// Assumes pins already synchronous to sys_clk.
`timescale 1ns/1ps
module ctc_edge_detect (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [1:0] level,
    output logic [1:0] prev,
    output logic [1:0] rise,
    output logic [1:0] fall
);
    // ======================================================
    // State
    ctc_pkg::ctc_edge_state_type state_r;
    ctc_pkg::ctc_edge_state_type state_nxt;

    // Remember last level; first cycle after reset sees no edge
    always_comb begin
        state_nxt = state_r;
        state_nxt.prev = level;
        state_nxt.primed = 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign prev = state_r.prev;

    // Per-pin edges, gated until primed to avoid a false edge at release
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            assign rise[gi] = state_r.primed & level[gi] & ~state_r.prev[gi];
            assign fall[gi] = state_r.primed & ~level[gi] & state_r.prev[gi];
        end
    endgenerate
endmodule

/* design/ctc_core_timer.sv */
// Core 16-bit up/down timer with its control and status register.
// Assumes a plain register port with one-cycle strobes and pins
// synchronous to sys_clk; reserved mode values are never written.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module ctc_core_timer (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire ctc_pkg::ctc_bus_type bus,
    output logic [15:0] rdata,
    input wire ctc_pkg::ctc_pins_type pins,
    output logic toggle_output_pin,
    output ctc_pkg::ctc_trig_type trig,
    output logic [15:0] core_timer,
    output logic overflow_pulse
);
    // ======================================================
    // State and decoded controls
    ctc_pkg::ctc_state_type state_r;
    ctc_pkg::ctc_state_type state_nxt;
    logic [1:0] pin_lvl;
    logic [1:0] pin_prev;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    logic [2:0] ipar;
    logic [2:0] mode;
    logic run;
    logic sw_dir_select;
    logic ext_dir_enable;
    logic toggle_output_enable;
    logic [3:0] bps_shift;
    logic [3:0] div_shift;
    logic [11:0] div_mask;
    logic tick;
    logic gate_ok;
    logic a_edge;
    logic b_edge;
    logic edge_hit;
    logic step;
    logic eff_down;
    logic wrap;
    logic wr_cnt;
    logic wr_ctl;

    assign pin_lvl = {pins.ext_dir_input, pins.gate_count_input};

    ctc_edge_detect u_edge (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .level(pin_lvl),
        .prev(pin_prev),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // ======================================================
    // Field decode from the stored control word, plus bus write strobes and pin edges
    assign ipar = state_r.ctl[ctc_pkg::POS_IPAR +: 3];
    assign mode = state_r.ctl[ctc_pkg::POS_MODE +: 3];
    assign run = state_r.ctl[ctc_pkg::POS_RUN];
    assign sw_dir_select = state_r.ctl[ctc_pkg::POS_SWDIR];
    assign ext_dir_enable = state_r.ctl[ctc_pkg::POS_EXTDIR];
    assign toggle_output_enable = state_r.ctl[ctc_pkg::POS_OE];
    assign wr_cnt = bus.wr && (bus.addr == ctc_pkg::ADDR_COUNT);
    assign wr_ctl = bus.wr && (bus.addr == ctc_pkg::ADDR_CONTROL);
    assign a_edge = pin_rise[0] | pin_fall[0];
    assign b_edge = pin_rise[1] | pin_fall[1];

    // Base clock select, then the mode prescaler on top of it
    always_comb begin
        case (state_r.ctl[ctc_pkg::POS_BPS +: 2])
            2'h0: bps_shift = ctc_pkg::BPS_SHIFT_0;
            2'h1: bps_shift = ctc_pkg::BPS_SHIFT_1;
            2'h2: bps_shift = ctc_pkg::BPS_SHIFT_2;
            default: bps_shift = ctc_pkg::BPS_SHIFT_3;
        endcase
    end
    // Power-of-two divide keeps the prescaler to one free counter
    assign div_shift = bps_shift + {1'b0, ipar};
    assign div_mask = ~(ctc_pkg::DIV_ONES << div_shift);
    assign tick = (state_r.div & div_mask) == div_mask;

    // ======================================================
    // Count event per mode
    always_comb begin
        gate_ok = 1'b0;
        edge_hit = 1'b0;
        step = 1'b0;
        case (mode)
            ctc_pkg::MODE_TIMER: begin
                step = run & tick;
            end
            ctc_pkg::MODE_GATED_LO, ctc_pkg::MODE_GATED_HI: begin
                // Low mode bit gives the gate's active level
                gate_ok = pins.gate_count_input == mode[0];
                step = run & tick & gate_ok;
            end
            ctc_pkg::MODE_COUNTER: begin
                case (ipar)
                    ctc_pkg::EDGE_RISE: edge_hit = pin_rise[0];
                    ctc_pkg::EDGE_FALL: edge_hit = pin_fall[0];
                    ctc_pkg::EDGE_BOTH: edge_hit = a_edge;
                    default: edge_hit = 1'b0;
                endcase
                step = run & edge_hit;
            end
            ctc_pkg::MODE_INCR_ROT, ctc_pkg::MODE_INCR_EDGE: begin
                case (ipar[1:0])
                    ctc_pkg::INCR_A: edge_hit = a_edge;
                    ctc_pkg::INCR_B: edge_hit = b_edge;
                    ctc_pkg::INCR_AB: edge_hit = a_edge | b_edge;
                    default: edge_hit = 1'b0;
                endcase
                step = run & edge_hit;
            end
            default: begin
                step = 1'b0; // Reserved modes hold the count
            end
        endcase
    end

    // ======================================================
    // Effective direction
    always_comb begin
        if (mode == ctc_pkg::MODE_INCR_ROT || mode == ctc_pkg::MODE_INCR_EDGE) begin
            eff_down = state_r.quad_down ^ sw_dir_select;
            if (edge_hit) begin
                // Phase relation after the edge gives the rotation sense
                eff_down = (a_edge ? ~(pin_lvl[0] ^ pin_lvl[1]) : (pin_lvl[0] ^ pin_lvl[1]))
                    ^ sw_dir_select;
            end
        end else if (ext_dir_enable) begin
            eff_down = pins.ext_dir_input ^ sw_dir_select;
        end else begin
            eff_down = sw_dir_select;
        end
    end

    assign wrap = step && (eff_down ? (state_r.cnt == ctc_pkg::COUNT_MIN)
        : (state_r.cnt == ctc_pkg::COUNT_MAX));

    // ======================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        state_nxt.div = state_r.div + ctc_pkg::DIV_STEP;
        state_nxt.ovf = 1'b0;
        state_nxt.rdata = 16'h0000;
        state_nxt.rdir = eff_down;
        if (edge_hit) begin
            state_nxt.quad_down = eff_down ^ sw_dir_select;
        end
        // Shadow trails the latch by one cycle; the gap is the trigger edge
        state_nxt.shadow = state_r.ctl[ctc_pkg::POS_OTL];
        // Count update; wrap in both directions
        if (step) begin
            if (eff_down) begin
                state_nxt.cnt = state_r.cnt - ctc_pkg::COUNT_STEP;
            end else begin
                state_nxt.cnt = state_r.cnt + ctc_pkg::COUNT_STEP;
            end
        end
        if (wr_cnt) begin
            state_nxt.cnt = bus.wdata;
        end else if (wrap) begin
            state_nxt.ovf = 1'b1;
            state_nxt.ctl[ctc_pkg::POS_OTL] = ~state_r.ctl[ctc_pkg::POS_OTL];
        end
        // Flags: hardware set always beats a software clear
        state_nxt.edge_flag = state_r.edge_flag | edge_hit;
        state_nxt.chdir = state_r.chdir | (eff_down != state_r.rdir);
        if (wr_ctl) begin
            state_nxt.ctl = bus.wdata[12:0];
            state_nxt.shadow = bus.wdata[ctc_pkg::POS_OTL];
            // Only a written zero clears; a written one keeps the flag
            state_nxt.edge_flag = edge_hit
                | (state_r.edge_flag & bus.wdata[ctc_pkg::POS_EDGE]);
            state_nxt.chdir = (eff_down != state_r.rdir)
                | (state_r.chdir & bus.wdata[ctc_pkg::POS_CHDIR]);
        end
        // Read data for the next cycle; unmapped reads give zero
        if (bus.rd) begin
            if (bus.addr == ctc_pkg::ADDR_CONTROL) begin
                state_nxt.rdata = {state_r.rdir, state_r.chdir, state_r.edge_flag, state_r.ctl};
            end else if (bus.addr == ctc_pkg::ADDR_COUNT) begin
                state_nxt.rdata = state_r.cnt;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ======================================================
    // Outputs
    assign rdata = state_r.rdata;
    assign core_timer = state_r.cnt;
    assign overflow_pulse = state_r.ovf;
    assign trig.toggle_latch = state_r.ctl[ctc_pkg::POS_OTL];
    assign trig.shadow_latch = state_r.shadow;
    // Disabled output idles high
    assign toggle_output_pin = toggle_output_enable ? state_r.ctl[ctc_pkg::POS_OTL] : 1'b1;

    // ======================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_cpu_write_wins: assert property (wr_cnt |=> state_r.cnt == $past(bus.wdata))
        else $error("count write lost to a count update");
    a_stopped_holds: assert property ((!run && !wr_cnt) |=> $stable(state_r.cnt))
        else $error("count moved while stopped");
    a_up_wrap_zero: assert property ((step && !eff_down && state_r.cnt == 16'hFFFF && !wr_cnt)
        |=> state_r.cnt == 16'h0000 && overflow_pulse)
        else $error("up count did not wrap to zero");
    a_down_wrap_max: assert property ((step && eff_down && state_r.cnt == 16'h0000 && !wr_cnt)
        |=> state_r.cnt == 16'hFFFF && overflow_pulse)
        else $error("down count did not wrap to max");
    a_latch_toggles: assert property ((wrap && !wr_cnt && !wr_ctl)
        |=> trig.toggle_latch != $past(trig.toggle_latch))
        else $error("toggle latch missed a wrap");
    // A second control write reloads both latches, so the trailing check yields to it
    a_shadow_matches: assert property (wr_ctl |=> trig.shadow_latch == trig.toggle_latch
        ##1 (trig.shadow_latch == $past(trig.toggle_latch) || $past(wr_ctl)))
        else $error("shadow latch mismatch");
    a_out_pin_level: assert property (toggle_output_pin
        == (toggle_output_enable ? trig.toggle_latch : 1'b1))
        else $error("toggle output pin wrong");
    a_edge_flag_sticky: assert property (edge_hit |=> state_r.edge_flag
        ##1 (state_r.edge_flag || $past(wr_ctl)))
        else $error("edge flag not set or not held");
    a_chdir_flag_set: assert property ((eff_down != state_r.rdir) |=> state_r.chdir)
        else $error("direction change flag not set");
    a_ext_dir_xor: assert property ((ext_dir_enable && mode[2:1] != 2'h3)
        |=> state_r.rdir == $past(pins.ext_dir_input ^ sw_dir_select))
        else $error("external direction not applied");
    a_gate_blocks: assert property ((mode[2:1] == 2'h1 && !gate_ok && !wr_cnt)
        |=> $stable(state_r.cnt))
        else $error("count moved with gate inactive");

    // ======================================================
    // Flag, direction and step checks
    a_edge_flag_clear: assert property ((wr_ctl && !bus.wdata[ctc_pkg::POS_EDGE] && !edge_hit)
        |=> !state_r.edge_flag)
        else $error("edge flag not cleared by a written zero");
    a_chdir_flag_clear: assert property ((wr_ctl && !bus.wdata[ctc_pkg::POS_CHDIR]
        && eff_down == state_r.rdir) |=> !state_r.chdir)
        else $error("direction change flag not cleared");
    a_flags_kept: assert property ((wr_ctl && bus.wdata[ctc_pkg::POS_EDGE]
        && bus.wdata[ctc_pkg::POS_CHDIR]) |=> (state_r.edge_flag || !$past(state_r.edge_flag))
        && (state_r.chdir || !$past(state_r.chdir)))
        else $error("flags lost on a control write");
    a_edge_real_change: assert property (edge_hit |-> pin_lvl != pin_prev)
        else $error("count edge without a pin change");
    a_sw_dir_applied: assert property ((!ext_dir_enable && mode[2:1] != 2'h3)
        |=> state_r.rdir == $past(sw_dir_select))
        else $error("software direction not applied");
    a_counter_idle: assert property ((mode == ctc_pkg::MODE_COUNTER && (ipar == 3'h0 || ipar[2])
        && !wr_cnt) |=> $stable(state_r.cnt))
        else $error("counter moved with no edge selected");
    a_timer_tick_only: assert property ((mode == ctc_pkg::MODE_TIMER && !tick && !wr_cnt)
        |=> $stable(state_r.cnt))
        else $error("timer moved between prescaler ticks");
    a_count_up_step: assert property ((step && !eff_down && !wr_cnt)
        |=> state_r.cnt == $past(state_r.cnt) + ctc_pkg::COUNT_STEP)
        else $error("up step did not add one");
    a_count_down_step: assert property ((step && eff_down && !wr_cnt)
        |=> state_r.cnt == $past(state_r.cnt) - ctc_pkg::COUNT_STEP)
        else $error("down step did not take one");

    c_overflow: cover property (overflow_pulse && !state_r.rdir);
    c_underflow: cover property (overflow_pulse && state_r.rdir);
    c_counter_edge: cover property (mode == ctc_pkg::MODE_COUNTER && step);
    c_dir_change: cover property (eff_down != state_r.rdir && run);
    c_gated_step: cover property (mode[2:1] == 2'h1 && step);
endmodule

/* bench/ctc_pin_model.sv */
// Pin source for the gate/count and external direction inputs.
// Assumes the bench asks for levels just after a rising edge.
`timescale 1ns/1ps
module ctc_pin_model (
    input wire logic sys_clk,
    input wire logic a_req,
    input wire logic b_req,
    output ctc_pkg::ctc_pins_type pins
);
    // ======================================================
    // Pins move only on an edge, as a synchronised pin would
    always_ff @(posedge sys_clk) begin
        pins.gate_count_input <= a_req;
        pins.ext_dir_input <= b_req;
    end
endmodule

/* bench/core_timer_control_bench.sv */
// Self-checking bench for the core timer control block.
// Assumes ctc_pkg and ctc_pin_model are compiled first.
`timescale 1ns/1ps
module core_timer_control_bench;
    // ======================================================
    // Signals
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    ctc_pkg::ctc_bus_type bus_q = '0;
    logic a_req = 1'b0;
    logic b_req = 1'b0;
    ctc_pkg::ctc_pins_type pins;
    ctc_pkg::ctc_trig_type trig;
    logic [15:0] rdata;
    logic [15:0] core_timer;
    logic toggle_output_pin;
    logic overflow_pulse;
    int err_count = 0;
    int checks = 0;
    logic [15:0] v;
    logic [15:0] s;
    logic [15:0] m;
    int n;

    // Clock, 25 ns period
    always #12.5 sys_clk = ~sys_clk;

    ctc_pin_model i_pins (.sys_clk(sys_clk), .a_req(a_req), .b_req(b_req), .pins(pins));
    ctc_core_timer i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus_q), .rdata(rdata), .pins(pins),
        .toggle_output_pin(toggle_output_pin), .trig(trig), .core_timer(core_timer),
        .overflow_pulse(overflow_pulse));

    // ======================================================
    // Helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Strobes drop at the edge that takes them, so the next call waits one edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus_q.addr <= a;
        bus_q.wdata <= d;
        bus_q.wr <= 1'b1;
        @(posedge sys_clk);
        bus_q.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        bus_q.addr <= a;
        bus_q.rd <= 1'b1;
        @(posedge sys_clk);
        bus_q.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Control word; f is {latch, out enable, ext dir, sw dir, run}
    function automatic logic [15:0] cv(input logic [1:0] bps, input logic [4:0] f, input logic [2:0] md,
        input logic [2:0] ip);
        return {3'h0, bps, f, md, ip};
    endfunction

    task automatic ab(input logic a, input logic b, input int hold);
        @(posedge sys_clk);
        a_req <= a;
        b_req <= b;
        repeat (hold) @(posedge sys_clk);
        #1;
    endtask

    // Bounded wait for the count to move; n gives the cycles waited
    task automatic wait_chg(output int n);
        logic [15:0] c;
        c = core_timer;
        n = 0;
        while (core_timer === c && n < 100) begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk("count moved", 16'h0001, {15'h0, core_timer !== c});
    endtask

    // ======================================================
    // Scenarios
    task automatic t_reset();
        rd(ctc_pkg::ADDR_CONTROL, v);
        chk("control reset", 16'h0000, v);
        rd(ctc_pkg::ADDR_COUNT, v);
        chk("count reset", 16'h0000, v);
        rd(16'hFF44, v);
        chk("unmapped read", 16'h0000, v);
        chk("idle out pin", 16'h0001, {15'h0, toggle_output_pin});
        wr(ctc_pkg::ADDR_COUNT, 16'hA5C3);
        rd(ctc_pkg::ADDR_COUNT, v);
        chk("count rw", 16'hA5C3, v);
        wr(ctc_pkg::ADDR_CONTROL, 16'h8000);
        rd(ctc_pkg::ADDR_CONTROL, v);
        chk("bit15 read only", 16'h0000, v);
    endtask

    task automatic t_periods();
        logic [1:0] bt[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
        logic [2:0] it[5] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1};
        int pt[5] = '{8, 4, 32, 16, 8};
        for (int i = 0; i < 5; i++) begin
            wr(ctc_pkg::ADDR_CONTROL, cv(bt[i], 5'h01, 3'h0, it[i]));
            wait_chg(n);
            s = core_timer;
            wait_chg(n);
            chk("tick period", 16'(pt[i]), 16'(n));
            chk("count up", s + 16'h0001, core_timer);
        end
    endtask

    task automatic t_run();
        wr(ctc_pkg::ADDR_CONTROL, cv(2'h1, 5'h00, 3'h0, 3'h0));
        s = core_timer;
        repeat (40) @(posedge sys_clk);
        chk("stopped", s, core_timer);
        wr(ctc_pkg::ADDR_CONTROL, cv(2'h1, 5'h03, 3'h0, 3'h0));
        wait_chg(n);
        s = core_timer;
        wait_chg(n);
        chk("count down", s - 16'h0001, core_timer);
    endtask

    task automatic t_dir();
        logic e;
        for (int i = 0; i < 8; i++) begin
            ab(1'b0, i[2], 1);
            wr(ctc_pkg::ADDR_CONTROL, cv(2'h0, {2'h0, i[1], i[0], 1'b0}, 3'h0, 3'h0));
            repeat (2) @(posedge sys_clk);
            rd(ctc_pkg::ADDR_CONTROL, v);
            e = i[1] ? (i[2] ^ i[0]) : i[0];
            chk("rotation dir", {15'h0, e}, {15'h0, v[15]});
        end
        chk("dir change set", 16'h0001, {15'h0, v[14]});
        wr(ctc_pkg::ADDR_CONTROL, {3'h3, v[12:0]});
        rd(ctc_pkg::ADDR_CONTROL, m);
        chk("flag kept", 16'h0001, {15'h0, m[14]});
        wr(ctc_pkg::ADDR_CONTROL, {3'h0, v[12:0]});
        rd(ctc_pkg::ADDR_CONTROL, m);
        chk("flag cleared", 16'h0000, {15'h0, m[14]});
    endtask

    task automatic t_counter();
        for (int ip = 0; ip < 4; ip++) begin
            ab(1'b0, 1'b0, 2);
            wr(ctc_pkg::ADDR_CONTROL, cv(2'h0, 5'h01, 3'h1, ip[2:0]));
            wr(ctc_pkg::ADDR_COUNT, 16'h0000);
            repeat (2) begin
                ab(1'b1, 1'b0, 4);
                ab(1'b0, 1'b0, 4);
            end
            chk("edge count", 16'(2 * (ip[0] + ip[1])), core_timer);
            rd(ctc_pkg::ADDR_CONTROL, v);
            chk("edge flag", {15'h0, ip != 0}, {15'h0, v[13]});
        end
    endtask

    task automatic t_gated();
        logic [2:0] md;
        for (int k = 2; k < 4; k++) begin
            md = k[2:0];
            ab(~md[0], 1'b0, 2);
            wr(ctc_pkg::ADDR_CONTROL, cv(2'h1, 5'h01, md, 3'h0));
            wr(ctc_pkg::ADDR_COUNT, 16'h0000);
            repeat (40) @(posedge sys_clk);
            chk("gate closed", 16'h0000, core_timer);
            ab(md[0], 1'b0, 40);
            chk("gate open", 16'h0001, {15'h0, core_timer != 16'h0000});
            wr(ctc_pkg::ADDR_CONTROL, cv(2'h1, 5'h00, md, 3'h0));
            s = core_timer;
            repeat (40) @(posedge sys_clk);
            chk("gate open stopped", s, core_timer);
        end
    endtask

    // Forward then reverse quadrature steps must return the count home
    task automatic t_incr();
        for (int k = 6; k < 8; k++) begin
            ab(1'b0, 1'b0, 2);
            wr(ctc_pkg::ADDR_CONTROL, cv(2'h0, 5'h01, k[2:0], 3'h3));
            s = core_timer;
            ab(1'b1, 1'b0, 4);
            ab(1'b1, 1'b1, 4);
            ab(1'b0, 1'b1, 4);
            ab(1'b0, 1'b0, 4);
            m = core_timer;
            ab(1'b0, 1'b1, 4);
            ab(1'b1, 1'b1, 4);
            ab(1'b1, 1'b0, 4);
            ab(1'b0, 1'b0, 4);
            chk("incr forward", 16'h0001, {15'h0, (m - s == 16'h4) || (s - m == 16'h4)});
            chk("incr back", s, core_timer);
        end
        // Phase A edges only: one forward cycle gives two steps
        wr(ctc_pkg::ADDR_CONTROL, cv(2'h0, 5'h01, 3'h6, 3'h1));
        s = core_timer;
        ab(1'b1, 1'b0, 4);
        ab(1'b1, 1'b1, 4);
        ab(1'b0, 1'b1, 4);
        ab(1'b0, 1'b0, 4);
        chk("incr a only", s + 16'h0002, core_timer);
    endtask

    // Back-to-back count writes while ticking every fourth cycle
    task automatic t_priority();
        wr(ctc_pkg::ADDR_CONTROL, cv(2'h1, 5'h01, 3'h0, 3'h0));
        @(posedge sys_clk);
        bus_q.addr <= ctc_pkg::ADDR_COUNT;
        bus_q.wr <= 1'b1;
        bus_q.wdata <= 16'h1000;
        for (int i = 1; i <= 8; i++) begin
            @(posedge sys_clk);
            bus_q.wdata <= 16'h1000 + 16'(i);
            bus_q.wr <= (i < 8);
            #1 chk("write wins", 16'h1000 + 16'(i - 1), core_timer);
        end
    endtask

    task automatic t_wrap();
        for (int d = 0; d < 2; d++) begin
            wr(ctc_pkg::ADDR_CONTROL, cv(2'h1, {3'h0, d[0], 1'b0}, 3'h0, 3'h0));
            wr(ctc_pkg::ADDR_COUNT, d[0] ? 16'h0000 : 16'hFFFF);
            wr(ctc_pkg::ADDR_CONTROL, cv(2'h1, {3'h0, d[0], 1'b1}, 3'h0, 3'h0));
            v = {15'h0, trig.toggle_latch};
            n = 0;
            while (overflow_pulse !== 1'b1 && n < 50) begin
                @(posedge sys_clk);
                #1 n++;
            end
            chk("overflow pulse", 16'h0001, {15'h0, overflow_pulse});
            chk("wrap value", d[0] ? 16'hFFFF : 16'h0000, core_timer);
            chk("latch toggled", {15'h0, ~v[0]}, {15'h0, trig.toggle_latch});
            @(posedge sys_clk);
            #1 chk("shadow follows", {15'h0, ~v[0]}, {15'h0, trig.shadow_latch});
            chk("pulse one cycle", 16'h0000, {15'h0, overflow_pulse});
        end
    endtask

    task automatic t_latch();
        logic [15:0] wt[3] = '{16'h0600, 16'h0200, 16'h0000};
        logic pt[3] = '{1'b1, 1'b0, 1'b1};
        logic lt[3] = '{1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 3; i++) begin
            wr(ctc_pkg::ADDR_CONTROL, wt[i]);
            #1 chk("out pin", {15'h0, pt[i]}, {15'h0, toggle_output_pin});
            chk("latch write", {15'h0, lt[i]}, {15'h0, trig.toggle_latch});
            chk("shadow write", {15'h0, lt[i]}, {15'h0, trig.shadow_latch});
        end
    endtask

    // ======================================================
    // Verdict, reached from the main sequence or the watchdog
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        $display("test reset done");
        t_periods();
        $display("test periods done");
        t_run();
        $display("test run done");
        t_dir();
        $display("test direction done");
        t_counter();
        $display("test counter done");
        t_gated();
        $display("test gated done");
        t_incr();
        $display("test incremental done");
        t_priority();
        $display("test priority done");
        t_wrap();
        $display("test wrap done");
        t_latch();
        $display("test latch done");
        print_verdict();
    end

    // Watchdog, over twenty times the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        print_verdict();
    end
endmodule
